/* io_flags_pkg.sv */
// Constants and state types for the I/O node interrupt flag block.
// Assumes the microprocessor presents full byte addresses on its address pins.
package io_flags_pkg;

  localparam int ADDR_W = 27;
  localparam int DATA_W = 16;
  localparam int MASK_W = 13;
  localparam int SYN_W  = 8;

  // Microprocessor addresses of the registers this block decodes or watches
  localparam logic [ADDR_W-1:0] ADDR_FLAG      = 27'h4000200;
  localparam logic [ADDR_W-1:0] ADDR_MASK      = 27'h4000220;
  localparam logic [ADDR_W-1:0] ADDR_CLEAR     = 27'h4001E00;
  localparam logic [ADDR_W-1:0] ADDR_SLOW_IN   = 27'h4000400;
  localparam logic [ADDR_W-1:0] ADDR_SLOW_OUT  = 27'h4000800;
  localparam logic [ADDR_W-1:0] ADDR_SYNDROME  = 27'h4001000;
  localparam logic [ADDR_W-1:0] ADDR_PROC_SCLR = 27'h4001C00;
  localparam logic [ADDR_W-1:0] ADDR_FAST_SCLR = 27'h4001C20;

  // Clear command register bit positions
  localparam int CLR_IN_CTRL   = 0;
  localparam int CLR_OUT_CTRL  = 1;
  localparam int CLR_FAST_ADDR = 2;
  localparam int CLR_FAST_DATA = 3;
  localparam int CLR_IN_ERR    = 7;
  localparam int CLR_OUT_ERR   = 8;
  localparam int CLR_IN_DISC   = 9;

  // Flag register bit positions
  localparam int FL_FAST_ERR  = 0;
  localparam int FL_PROC_SBE  = 1;
  localparam int FL_PROC_MBE  = 2;
  localparam int FL_FAST_SBE  = 3;
  localparam int FL_FAST_MBE  = 4;
  localparam int FL_ADDR_DONE = 5;
  localparam int FL_DATA_DONE = 6;
  localparam int FL_IN_AVAIL  = 7;
  localparam int FL_IN_DISC   = 8;
  localparam int FL_IN_ERR    = 9;
  localparam int FL_OUT_DONE  = 10;
  localparam int FL_OUT_ERR   = 11;
  localparam int FL_MCLR      = 12;
  localparam int FL_REV_LO    = 13;
  localparam int FL_SLAVE     = 15;

  localparam logic [MASK_W-1:0] MASK_RESET = 13'h0000;

  typedef struct packed {
    logic             sbe;
    logic             mbe;
    logic [SYN_W-1:0] syn;
  } ecc_state_t;

endpackage

/* ecc_track_if.sv */
// Carrier between the flag block and one error-check tracker.
// Assumes both ends share the system clock.
`timescale 1ns/1ns
interface ecc_track_if;
  logic                            enable;
  logic                            clr;
  logic                            single_ev;
  logic                            multi_ev;
  logic [io_flags_pkg::SYN_W-1:0]  ev_syn;
  logic                            sbe;
  logic                            mbe;
  logic [io_flags_pkg::SYN_W-1:0]  syn;

  modport owner   (output enable, clr, single_ev, multi_ev, ev_syn, input sbe, mbe, syn);
  modport tracker (input enable, clr, single_ev, multi_ev, ev_syn, output sbe, mbe, syn);
endinterface

/* ecc_flag_tracker.sv */
// Single-bit and multi-bit error flags with their captured syndrome.
// Assumes error events are one-cycle pulses synchronous to clk.
`timescale 1ns/1ns
module ecc_flag_tracker (
  input  wire logic    clk,
  input  wire logic    rst_n,
  ecc_track_if.tracker trk
);

  io_flags_pkg::ecc_state_t st_r;
  io_flags_pkg::ecc_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (trk.clr) begin
      st_nxt.sbe = 1'b0;
      st_nxt.mbe = 1'b0;
    end
    // Event after clear, so an error in the clearing cycle survives
    if (trk.multi_ev) begin
      if (!st_nxt.mbe) begin
        st_nxt.syn = trk.ev_syn;
      end
      st_nxt.mbe = 1'b1;
      st_nxt.sbe = 1'b0;
    end else if (trk.single_ev && !st_nxt.mbe) begin
      st_nxt.sbe = 1'b1;
      st_nxt.syn = trk.ev_syn;
    end
    if (!trk.enable) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trk.sbe = st_r.sbe;
  assign trk.mbe = st_r.mbe;
  assign trk.syn = st_r.syn;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_mbe_stays_set: assert property (st_r.mbe && trk.enable && !trk.clr |=> st_r.mbe)
    else $error("multi-bit flag dropped without clear");
  a_mbe_syn_held: assert property (st_r.mbe && trk.enable && !trk.clr |=> $stable(st_r.syn))
    else $error("syndrome changed while multi-bit flag held");
  a_clear_drops: assert property (trk.clr && !trk.multi_ev && !trk.single_ev |=> !st_r.mbe && !st_r.sbe)
    else $error("syndrome clear did not drop flags");
  a_multi_kills_sbe: assert property (trk.enable && trk.multi_ev && !st_r.mbe
      |=> st_r.mbe && !st_r.sbe && st_r.syn == $past(trk.ev_syn))
    else $error("multi-bit error did not replace single-bit state");
  c_single_then_multi: cover property (st_r.sbe ##[1:8] st_r.mbe);

endmodule

/* io_node_interrupt_flags.sv */
// Interrupt flag, mask and interrupt output of an I/O gateway node.
// Assumes processor strobes and channel events are synchronous one-cycle pulses.
//
// Notes on behaviour
// - Processor multi-bit flag sets on errors writing slow output or fast buffer.
// - Any write to processor syndrome clear drops the processor multi-bit flag.
// - Processor multi-bit flag stays set; syndrome keeps first multi-bit error.
// - Input node: fast single-bit flag sets on input check; syndrome clear drops it.
// - Output node: fast single-bit and multi-bit flags always read zero.
// - Single-bit flag tracks latest syndrome; multi-bit error drops it, captures syndrome.
// - Input node: fast multi-bit flag sticky, first syndrome, cleared by syndrome clear.
// - Address transfer complete sets on address sent/received; clear bit 2.
// - Data transfer complete sets on last word or length zero; clear bit 3.
// - Input data available sets on disconnect or full; cleared by read or bit 0.
// - Input disconnect sets on last word read; clear bit 0 or 9.
// - Input error sets on parity or sequence error; clear bit 0 or 7.
// - Output complete sets when output drains; cleared by data write or bit 1.
// - Output complete means ownership after first word, empty buffer after last.
// - Output error sets on output parity or sequence error; clear bit 1 or 8.
// - Master clear flag follows the live host reset signal.
// - Revision level is a two-bit read-only field at bits 13 and 14.
// - Bit 15 reads zero in a master node, one in a slave node.
// - Interrupt mask is a 13-bit readable and writable register.
// - A flag raises the interrupt only when its mask bit is one.
// - Flags show channel conditions regardless of mask.
`timescale 1ns/1ns
module io_node_interrupt_flags #(
  parameter bit       IS_INPUT_NODE = 1'b1,
  parameter bit       IS_SLAVE      = 1'b0,
  parameter bit [1:0] REVISION      = 2'h2 // Arbitrary value
) (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic [io_flags_pkg::ADDR_W-1:0]   cpu_addr,
  input  wire logic                              cpu_rd,
  input  wire logic                              cpu_wr,
  input  wire logic [io_flags_pkg::DATA_W-1:0]   cpu_wdata,
  output logic      [io_flags_pkg::DATA_W-1:0]   cpu_rdata,
  output logic                                   cpu_rvalid,
  input  wire logic                              fast_error_level,
  input  wire logic                              proc_single_err,
  input  wire logic                              proc_multi_err,
  input  wire logic [io_flags_pkg::SYN_W-1:0]    proc_err_syn,
  input  wire logic                              fast_single_err,
  input  wire logic                              fast_multi_err,
  input  wire logic [io_flags_pkg::SYN_W-1:0]    fast_err_syn,
  input  wire logic                              addr_xfer_done,
  input  wire logic                              fast_last_word,
  input  wire logic                              block_len_zero,
  input  wire logic                              slow_in_disconnect,
  input  wire logic                              slow_in_buf_full,
  input  wire logic                              slow_in_last_word,
  input  wire logic                              slow_in_parity_err,
  input  wire logic                              slow_in_seq_err,
  input  wire logic                              slow_out_drained,
  input  wire logic                              slow_out_parity_err,
  input  wire logic                              slow_out_seq_err,
  input  wire logic                              master_clear_in,
  output logic                                   io_irq
);

  // Flag layout is fixed, so other widths cannot be served
  if (io_flags_pkg::MASK_W != 13 || io_flags_pkg::DATA_W < 16) begin : g_bad_widths
    $error("flag block needs a 13-bit mask and 16-bit data");
  end

  typedef struct packed {
    logic                              fast_err;
    logic                              addr_done;
    logic                              data_done;
    logic                              in_avail;
    logic                              in_disc;
    logic                              in_err;
    logic                              out_done;
    logic                              out_err;
    logic                              mclr;
    logic [io_flags_pkg::MASK_W-1:0]   mask;
    logic [io_flags_pkg::DATA_W-1:0]   rdata;
    logic                              rvalid;
    logic                              irq;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  ecc_track_if proc_trk ();
  ecc_track_if fast_trk ();

  ecc_flag_tracker u_proc_ecc (
    .clk   (clk),
    .rst_n (rst_n),
    .trk   (proc_trk.tracker)
  );

  ecc_flag_tracker u_fast_ecc (
    .clk   (clk),
    .rst_n (rst_n),
    .trk   (fast_trk.tracker)
  );

  logic                            wr_clear;
  logic                            wr_mask;
  logic [io_flags_pkg::DATA_W-1:0] clr_bits;
  logic [io_flags_pkg::DATA_W-1:0] flag_vec;

  function automatic logic hit(input logic [io_flags_pkg::ADDR_W-1:0] a,
                               input logic [io_flags_pkg::ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Flag word is built from live state only; the mask never touches it
  function automatic logic [io_flags_pkg::DATA_W-1:0] build_flags(input state_t s,
      input logic p_sbe, input logic p_mbe, input logic f_sbe, input logic f_mbe);
    logic [io_flags_pkg::DATA_W-1:0] f;
    f = '0;
    f[io_flags_pkg::FL_FAST_ERR]  = s.fast_err;
    f[io_flags_pkg::FL_PROC_SBE]  = p_sbe;
    f[io_flags_pkg::FL_PROC_MBE]  = p_mbe;
    f[io_flags_pkg::FL_FAST_SBE]  = f_sbe;
    f[io_flags_pkg::FL_FAST_MBE]  = f_mbe;
    f[io_flags_pkg::FL_ADDR_DONE] = s.addr_done;
    f[io_flags_pkg::FL_DATA_DONE] = s.data_done;
    f[io_flags_pkg::FL_IN_AVAIL]  = s.in_avail;
    f[io_flags_pkg::FL_IN_DISC]   = s.in_disc;
    f[io_flags_pkg::FL_IN_ERR]    = s.in_err;
    f[io_flags_pkg::FL_OUT_DONE]  = s.out_done;
    f[io_flags_pkg::FL_OUT_ERR]   = s.out_err;
    f[io_flags_pkg::FL_MCLR]      = s.mclr;
    f[io_flags_pkg::FL_REV_LO +: 2] = REVISION;
    f[io_flags_pkg::FL_SLAVE]     = IS_SLAVE;
    build_flags = f;
  endfunction

  assign wr_clear = cpu_wr && hit(cpu_addr, io_flags_pkg::ADDR_CLEAR);
  assign wr_mask  = cpu_wr && hit(cpu_addr, io_flags_pkg::ADDR_MASK);
  assign clr_bits = wr_clear ? cpu_wdata : '0;
  assign flag_vec = build_flags(st_r, proc_trk.sbe, proc_trk.mbe, fast_trk.sbe, fast_trk.mbe);

  // Error-check trackers
  assign proc_trk.enable    = 1'b1;
  assign proc_trk.clr       = cpu_wr && hit(cpu_addr, io_flags_pkg::ADDR_PROC_SCLR);
  assign proc_trk.single_ev = proc_single_err;
  assign proc_trk.multi_ev  = proc_multi_err;
  assign proc_trk.ev_syn    = proc_err_syn;

  // Output node keeps the fast-channel check held at zero
  assign fast_trk.enable    = IS_INPUT_NODE;
  assign fast_trk.clr       = cpu_wr && hit(cpu_addr, io_flags_pkg::ADDR_FAST_SCLR);
  assign fast_trk.single_ev = fast_single_err;
  assign fast_trk.multi_ev  = fast_multi_err;
  assign fast_trk.ev_syn    = fast_err_syn;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = cpu_rd;
    st_nxt.rdata  = '0;

    // Clears first, sets after: an event in the clearing cycle wins
    if (clr_bits[io_flags_pkg::CLR_FAST_ADDR]) begin
      st_nxt.addr_done = 1'b0;
    end
    if (clr_bits[io_flags_pkg::CLR_FAST_DATA]) begin
      st_nxt.data_done = 1'b0;
    end
    if (clr_bits[io_flags_pkg::CLR_IN_CTRL]
        || (cpu_rd && hit(cpu_addr, io_flags_pkg::ADDR_SLOW_IN))) begin
      st_nxt.in_avail = 1'b0;
    end
    if (clr_bits[io_flags_pkg::CLR_IN_CTRL] || clr_bits[io_flags_pkg::CLR_IN_DISC]) begin
      st_nxt.in_disc = 1'b0;
    end
    if (clr_bits[io_flags_pkg::CLR_IN_CTRL] || clr_bits[io_flags_pkg::CLR_IN_ERR]) begin
      st_nxt.in_err = 1'b0;
    end
    if (clr_bits[io_flags_pkg::CLR_OUT_CTRL]
        || (cpu_wr && hit(cpu_addr, io_flags_pkg::ADDR_SLOW_OUT))) begin
      st_nxt.out_done = 1'b0;
    end
    if (clr_bits[io_flags_pkg::CLR_OUT_CTRL] || clr_bits[io_flags_pkg::CLR_OUT_ERR]) begin
      st_nxt.out_err = 1'b0;
    end

    if (addr_xfer_done) begin
      st_nxt.addr_done = 1'b1;
    end
    if (fast_last_word || block_len_zero) begin
      st_nxt.data_done = 1'b1;
    end
    if (slow_in_disconnect || slow_in_buf_full) begin
      st_nxt.in_avail = 1'b1;
    end
    if (cpu_rd && hit(cpu_addr, io_flags_pkg::ADDR_SLOW_IN) && slow_in_last_word) begin
      st_nxt.in_disc = 1'b1;
    end
    if (slow_in_parity_err || slow_in_seq_err) begin
      st_nxt.in_err = 1'b1;
    end
    // Drain covers both first-word ownership and empty-buffer cases
    if (slow_out_drained) begin
      st_nxt.out_done = 1'b1;
    end
    if (slow_out_parity_err || slow_out_seq_err) begin
      st_nxt.out_err = 1'b1;
    end

    st_nxt.fast_err = fast_error_level;
    st_nxt.mclr     = master_clear_in;

    if (wr_mask) begin
      st_nxt.mask = cpu_wdata[io_flags_pkg::MASK_W-1:0];
    end

    if (cpu_rd) begin
      case (1'b1)
        hit(cpu_addr, io_flags_pkg::ADDR_FLAG): begin
          st_nxt.rdata = flag_vec;
        end
        hit(cpu_addr, io_flags_pkg::ADDR_MASK): begin
          st_nxt.rdata[io_flags_pkg::MASK_W-1:0] = st_r.mask;
          // Live master clear also shows here; the read returns it ORed with mask bit 12
          st_nxt.rdata[io_flags_pkg::FL_MCLR] = st_r.mask[io_flags_pkg::FL_MCLR] | st_r.mclr;
        end
        hit(cpu_addr, io_flags_pkg::ADDR_SYNDROME): begin
          st_nxt.rdata = {fast_trk.syn, proc_trk.syn};
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    st_nxt.irq = |(flag_vec[io_flags_pkg::MASK_W-1:0] & st_r.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.mask <= io_flags_pkg::MASK_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_rdata  = st_r.rdata;
  assign cpu_rvalid = st_r.rvalid;
  assign io_irq     = st_r.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_irq_from_mask: assert property (##1 io_irq == $past(|(flag_vec[12:0] & st_r.mask)))
    else $error("interrupt does not match masked flags");
  a_masked_quiet: assert property (st_r.mask == 13'h0000 |=> !io_irq)
    else $error("interrupt raised with all flags masked");
  a_out_node_zero: assert property (!IS_INPUT_NODE |-> !fast_trk.sbe && !fast_trk.mbe)
    else $error("fast error flags set in output node");
  a_addr_done_clr: assert property (wr_clear && cpu_wdata[2] && !addr_xfer_done
      |=> !st_r.addr_done)
    else $error("address complete not cleared");
  a_data_done_set: assert property (fast_last_word || block_len_zero |=> st_r.data_done)
    else $error("data complete not set");
  a_in_avail_read: assert property (cpu_rd && cpu_addr == 27'h4000400
      && !slow_in_disconnect && !slow_in_buf_full |=> !st_r.in_avail)
    else $error("input data available not cleared by read");
  a_in_err_hold: assert property (st_r.in_err && !clr_bits[0] && !clr_bits[7] |=> st_r.in_err)
    else $error("input error dropped without clear");
  a_out_done_write: assert property (cpu_wr && cpu_addr == 27'h4000800
      && !slow_out_drained |=> !st_r.out_done)
    else $error("output complete not cleared by data write");
  a_out_err_set: assert property (slow_out_parity_err || slow_out_seq_err |=> st_r.out_err)
    else $error("output error not set");
  a_mclr_follow: assert property (##1 st_r.mclr == $past(master_clear_in))
    else $error("master clear flag does not follow input");
  a_node_bits: assert property (cpu_rd && cpu_addr == 27'h4000200
      |=> cpu_rvalid && cpu_rdata[15] == IS_SLAVE && cpu_rdata[14:13] == REVISION)
    else $error("node type or revision bits wrong");
  a_mask_write: assert property (wr_mask |=> st_r.mask == $past(cpu_wdata[12:0]))
    else $error("mask write not taken");
  a_addr_done_set: assert property (addr_xfer_done |=> st_r.addr_done)
    else $error("address complete not set");
  a_data_done_clr: assert property (wr_clear && cpu_wdata[3] && !fast_last_word
      && !block_len_zero |=> !st_r.data_done)
    else $error("data complete not cleared");
  a_in_avail_set: assert property (slow_in_disconnect || slow_in_buf_full
      |=> st_r.in_avail)
    else $error("input data available not set");
  a_in_disc_set: assert property (cpu_rd && cpu_addr == 27'h4000400
      && slow_in_last_word |=> st_r.in_disc)
    else $error("input disconnect not set on last read");
  a_out_err_hold: assert property (st_r.out_err && !clr_bits[1] && !clr_bits[8]
      |=> st_r.out_err)
    else $error("output error dropped without clear");

  c_irq_raised: cover property (!io_irq ##1 io_irq);
  c_in_disc: cover property (st_r.in_avail ##[1:8] st_r.in_disc);
  c_out_drain: cover property (slow_out_drained ##1 st_r.out_done);

endmodule

/* host_chan_model.sv */
// Host channel model: turns bench fire requests into one-cycle event pulses.
// Assumes the bench raises fire for one cycle just after a rising edge.
`timescale 1ns/1ns
module host_chan_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [13:0] fire,
  input  wire logic [7:0]  syn_in,
  input  wire logic [2:0]  lvl,
  output logic      [13:0] ev,
  output logic      [7:0]  syn,
  output logic      [2:0]  lvl_o
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
      syn <= 8'hA5;
    end else begin
      ev <= fire;
      // Stale syndrome keeps toggling so it never passes for a valid one
      if (|fire) begin
        syn <= syn_in;
      end else begin
        syn <= ~syn;
      end
    end
  end
  // Host levels: last-word, master clear, fast error
  assign lvl_o = lvl;
endmodule

/* test_io_node_interrupt_flags.sv */
// Self-checking bench of the interrupt flag block.
// Assumes default parameters: input node, master, revision 2'h2.
// A second copy runs as a slave output node on the same stimulus.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module test_io_node_interrupt_flags;
  logic                            clk, rst_n, cpu_rd, cpu_wr, cpu_rvalid, io_irq;
  logic [io_flags_pkg::ADDR_W-1:0] cpu_addr;
  logic [15:0]                     cpu_wdata, cpu_rdata, rv, out_rdata;
  logic [13:0]                     fire, ev;
  logic [7:0]                      syn_in, syn;
  logic [2:0]                      lvl, lv;
  int                              n_fail, n_checks;
  localparam logic [15:0] ID  = 16'h4000;
  localparam int          EVI [10] = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13};
  localparam int          FB  [10] = '{5, 6, 6, 7, 7, 9, 9, 10, 11, 11};
  localparam int          CB  [10] = '{2, 3, 3, 0, 0, 7, 0, 1, 8, 1};

  host_chan_model host (.clk(clk), .rst_n(rst_n), .fire(fire), .syn_in(syn_in),
    .lvl(lvl), .ev(ev), .syn(syn), .lvl_o(lv));

  io_node_interrupt_flags dut (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .fast_error_level(lv[0]), .master_clear_in(lv[1]),
    .proc_single_err(ev[0]), .proc_multi_err(ev[1]), .proc_err_syn(syn),
    .fast_single_err(ev[2]), .fast_multi_err(ev[3]), .fast_err_syn(syn),
    .addr_xfer_done(ev[4]), .fast_last_word(ev[5]), .block_len_zero(ev[6]),
    .slow_in_disconnect(ev[7]), .slow_in_buf_full(ev[8]), .slow_in_last_word(lv[2]),
    .slow_in_parity_err(ev[9]), .slow_in_seq_err(ev[10]), .slow_out_drained(ev[11]),
    .slow_out_parity_err(ev[12]), .slow_out_seq_err(ev[13]), .io_irq(io_irq));

  io_node_interrupt_flags #(.IS_INPUT_NODE(1'b0), .IS_SLAVE(1'b1)) dut_out (.clk(clk),
    .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(out_rdata), .cpu_rvalid(), .fast_error_level(lv[0]),
    .master_clear_in(lv[1]), .proc_single_err(ev[0]), .proc_multi_err(ev[1]),
    .proc_err_syn(syn), .fast_single_err(ev[2]), .fast_multi_err(ev[3]),
    .fast_err_syn(syn), .addr_xfer_done(ev[4]), .fast_last_word(ev[5]),
    .block_len_zero(ev[6]), .slow_in_disconnect(ev[7]), .slow_in_buf_full(ev[8]),
    .slow_in_last_word(lv[2]), .slow_in_parity_err(ev[9]), .slow_in_seq_err(ev[10]),
    .slow_out_drained(ev[11]), .slow_out_parity_err(ev[12]), .slow_out_seq_err(ev[13]),
    .io_irq());

  task automatic wr(input logic [26:0] a, input logic [15:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  task automatic rd(input logic [26:0] a, output logic [15:0] d);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1;
    `CHK(cpu_rvalid, 1'b1)
    d = cpu_rdata;
  endtask

  task automatic chk_flags(input logic [15:0] e);
    rd(io_flags_pkg::ADDR_FLAG, rv);
    `CHK(rv, e)
  endtask

  // Returns at the edge where the block takes the pulse
  task automatic pulse(input int i, input logic [7:0] s);
    @(posedge clk);
    fire <= 14'h0001 << i;
    syn_in <= s;
    @(posedge clk);
    fire <= '0;
    @(posedge clk);
  endtask

  task automatic t_reset;
    chk_flags(ID);
    `CHK(out_rdata, ID | 16'h8000)
    rd(io_flags_pkg::ADDR_MASK, rv);
    `CHK(rv, 16'h0000)
    `CHK(io_irq, 1'b0)
    rd(27'h4000004, rv);
    `CHK(rv, 16'h0000)
    $display("reset test done");
  endtask

  task automatic t_mask;
    wr(io_flags_pkg::ADDR_MASK, 16'hFFFF);
    rd(io_flags_pkg::ADDR_MASK, rv);
    `CHK(rv, 16'h1FFF)
    wr(io_flags_pkg::ADDR_FLAG, 16'hFFFF);
    chk_flags(ID);
    `CHK(io_irq, 1'b0)
    wr(io_flags_pkg::ADDR_MASK, 16'h0000);
    $display("mask test done");
  endtask

  task automatic t_events;
    for (int k = 0; k < 10; k++) begin
      pulse(EVI[k], 8'h00);
      chk_flags(ID | (16'h0001 << FB[k]));
      wr(io_flags_pkg::ADDR_CLEAR, 16'h0001 << CB[k]);
      chk_flags(ID);
    end
    $display("event test done");
  endtask

  task automatic t_side;
    pulse(7, 8'h00);
    @(posedge clk);
    lvl <= 3'b100;
    rd(io_flags_pkg::ADDR_SLOW_IN, rv);
    chk_flags(ID | 16'h0100);
    @(posedge clk);
    lvl <= 3'b000;
    wr(io_flags_pkg::ADDR_CLEAR, 16'h0200);
    chk_flags(ID);
    pulse(11, 8'h00);
    chk_flags(ID | 16'h0400);
    wr(io_flags_pkg::ADDR_SLOW_OUT, 16'h1234);
    chk_flags(ID);
    $display("side effect test done");
  endtask

  task automatic t_irq;
    wr(io_flags_pkg::ADDR_MASK, 16'h0400);
    pulse(4, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK(io_irq, 1'b0)
    pulse(11, 8'h00);
    #1;
    `CHK(io_irq, 1'b0)
    @(posedge clk);
    #1;
    `CHK(io_irq, 1'b1)
    wr(io_flags_pkg::ADDR_CLEAR, 16'h0006);
    repeat (2) @(posedge clk);
    #1;
    `CHK(io_irq, 1'b0)
    wr(io_flags_pkg::ADDR_MASK, 16'h0000);
    $display("interrupt test done");
  endtask

  task automatic t_ecc;
    pulse(0, 8'h11);
    pulse(1, 8'h22);
    chk_flags(ID | 16'h0004);
    pulse(0, 8'h33);
    pulse(1, 8'h44);
    chk_flags(ID | 16'h0004);
    rd(io_flags_pkg::ADDR_SYNDROME, rv);
    `CHK(rv[7:0], 8'h22)
    wr(io_flags_pkg::ADDR_PROC_SCLR, 16'h0000);
    chk_flags(ID);
    pulse(2, 8'h55);
    pulse(2, 8'h66);
    chk_flags(ID | 16'h0008);
    `CHK(out_rdata, ID | 16'h8000)
    rd(io_flags_pkg::ADDR_SYNDROME, rv);
    `CHK(rv[15:8], 8'h66)
    pulse(3, 8'h77);
    chk_flags(ID | 16'h0010);
    `CHK(out_rdata, ID | 16'h8000)
    pulse(3, 8'h88);
    pulse(2, 8'h99);
    chk_flags(ID | 16'h0010);
    rd(io_flags_pkg::ADDR_SYNDROME, rv);
    `CHK(rv[15:8], 8'h77)
    wr(io_flags_pkg::ADDR_FAST_SCLR, 16'h0000);
    chk_flags(ID);
    $display("error check test done");
  endtask

  task automatic t_level;
    @(posedge clk);
    lvl <= 3'b011;
    chk_flags(ID | 16'h1001);
    rd(io_flags_pkg::ADDR_MASK, rv);
    `CHK(rv[12], 1'b1)
    @(posedge clk);
    lvl <= 3'b000;
    chk_flags(ID);
    $display("level test done");
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #200000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_addr = '0;
    cpu_wdata = '0;
    fire = '0;
    syn_in = '0;
    lvl = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mask();
    t_events();
    t_side();
    t_irq();
    t_ecc();
    t_level();
    print_verdict();
  end
endmodule
